// ### include/wbrs_pkg.sv
/*
  Constants, register map and carrier types of the watchdog and
  bidirectional reset sequencer.
  Assumes one CPU clock unit per pclk cycle at 10 MHz, and a 32-bit APB.
*/
// Behaviour
// [R1] An unserviced, enabled watchdog overflows and starts the internal reset sequence.
// [R2] Watchdog reset first completes a bus cycle without ready, or with ready low.
// [R3] Watchdog reset aborts a bus cycle whose ready is high after waits.
// [R4] Watchdog end latches config bits 12..8 and sets held bits 7..2 to one.
// [R5] Watchdog reset is always synchronous whatever the power-down pin level.
// [R6] Bidirectional watchdog reset drives reset input low only while power-down pin high.
// [R7] Reset output pin goes low at the start of every reset sequence.
// [R8] Reset output stays low until the end-of-init instruction completes.
// [R9] Bit 3 of the system configuration register enables bidirectional reset.
// [R10] The enable bit can be set only before end-of-init has completed.
// [R11] With bidirectional enabled, reset input is pulled down for the whole sequence.
// [R12] Short bidirectional hardware reset samples filtered input 8 units after the end.
// [R13] Bidir software/watchdog reset becomes short hardware reset if input stays low 4 units.
// [R14] Power-down pin low at a software/watchdog event blocks the pull-down.
// [R15] Power-down pin falling mid-sequence releases reset input; sequence still completes.
// [R16] Every reset sequence clears the bidirectional enable bit.
// [R17] Filtered input still low after bidir reset starts hardware reset, replacing flags.
// [R18] With the pull-up config bit set, power-down pull-up turns on after sequence.
// [R19] Weak power-down pull-down is on whenever reset input is low.
// [R20] Reset input low with power-down pin low gives asynchronous hardware reset.
// [R21] The end-of-sequence sample flags short if high, and long too if low.
// [R22] Sequence lasts 1024 units after an initial delay of 16 units.
// [R23] All decisions use the filtered reset input, never the raw pin.
package wbrs_pkg;

  localparam int CLK_NS                = 100;
  localparam int CPU_CLOCK_UNIT_NS     = 100;
  localparam int CPU_CLOCK_UNIT_CYCLES = (CPU_CLOCK_UNIT_NS + CLK_NS - 1) / CLK_NS;

  localparam int START_TCL  = 16;
  localparam int SEQ_TCL    = 1024;
  localparam int SAMPLE_TCL = 8;
  localparam int SHORT_TCL  = 4;
  localparam int FILT_TCL   = 4;

  localparam logic [10:0] START_CYC  = 11'(START_TCL * CPU_CLOCK_UNIT_CYCLES);
  localparam logic [10:0] SEQ_CYC    = 11'(SEQ_TCL * CPU_CLOCK_UNIT_CYCLES);
  localparam logic [10:0] SAMPLE_CYC = 11'(SAMPLE_TCL * CPU_CLOCK_UNIT_CYCLES);
  localparam logic [10:0] SHORT_CYC  = 11'(SHORT_TCL * CPU_CLOCK_UNIT_CYCLES);
  localparam logic [2:0]  FILT_CYC   = 3'(FILT_TCL * CPU_CLOCK_UNIT_CYCLES);

  localparam logic [7:0] ADDR_SYSCFG = 8'h00;
  localparam logic [7:0] ADDR_WDTRLD = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CFGLAT = 8'h10;

  localparam int BIT_BIDIR_EN  = 3;
  localparam int BIT_PWD_CFG   = 5;
  localparam int BIT_WDT_SERV  = 0;
  localparam int BIT_WDT_OFF   = 1;
  localparam int BIT_SW_RESET  = 2;
  localparam int BIT_END_INIT  = 3;

  localparam logic [15:0] WDT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] WDT_TOP        = 16'hFFFF;
  localparam logic [4:0]  CFG_HI_MASK_LO = 5'h1F;
  localparam logic [5:0]  CFG_MID_ONES   = 6'h3F;

  typedef enum logic [2:0] {
    WBRS_R_NONE, WBRS_R_SYSCFG, WBRS_R_WDTRLD, WBRS_R_CMD, WBRS_R_STATUS, WBRS_R_CFGLAT
  } wbrs_reg_t;

  typedef enum logic [1:0] {SRC_HW, SRC_SW, SRC_WDT} wbrs_src_t;

  typedef struct packed {
    logic long_hw;
    logic short_hw;
    logic sw;
    logic wdt;
  } wbrs_flags_t;

  typedef struct packed {
    logic active;
    logic uses_ready;
    logic waits_done;
    logic ready_n;
  } wbrs_bus_t;

endpackage

// ### logic/wbrs_seq.sv
/*
  Watchdog and bidirectional reset sequencer with an APB register slave.
  Assumes all pin inputs are synchronous to pclk and that one CPU clock
  unit equals one pclk cycle.
*/
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module wbrs_seq
  import wbrs_pkg::*;
#(
  parameter int WDT_PRESCALE = 2
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset pins.
  input  wire logic        reset_in_pin,
  output logic             reset_in_out,
  output logic             reset_in_oe_n,
  output logic             reset_out_pin_n,
  input  wire logic        powerdown_reset_pin,
  output logic             rpd_pulldown_en,
  output logic             rpd_pullup_en,
  // External bus and configuration port.
  input  wire wbrs_bus_t   ext_bus,
  output logic             bus_abort,
  input  wire logic [15:0] config_port,
  // Core reset.
  output logic             core_reset,
  output logic             async_reset
);

  typedef enum logic [2:0] {S_IDLE, S_BUSW, S_START, S_SEQ, S_POST, S_EXT, S_CHK, S_ASYNC}
    wbrs_state_t;

  function automatic wbrs_reg_t reg_sel(input logic [7:0] a);
    case (a)
      ADDR_SYSCFG: reg_sel = WBRS_R_SYSCFG;
      ADDR_WDTRLD: reg_sel = WBRS_R_WDTRLD;
      ADDR_CMD:    reg_sel = WBRS_R_CMD;
      ADDR_STATUS: reg_sel = WBRS_R_STATUS;
      ADDR_CFGLAT: reg_sel = WBRS_R_CFGLAT;
      default:     reg_sel = WBRS_R_NONE;
    endcase
  endfunction

  wbrs_state_t  st_q;
  wbrs_src_t    src_q;
  wbrs_flags_t  flags_q;
  logic [10:0]  cnt_q;
  logic         bd_q;
  logic         bd_sel_q;
  logic         bidir_en_q;
  logic         pwd_cfg_q;
  logic         end_of_init_instr_done_q;
  logic [15:0]  wdt_reload_q;
  logic [15:0]  wdt_cnt_q;
  logic         wdt_off_q;
  logic [7:0]   div_q;
  logic [15:0]  cfg_lat_q;
  logic [2:0]   filt_cnt_q;
  logic         filt_q;
  logic         sw_req_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         reset_out_q;
  logic         oe_n_q;
  logic         pd_q;
  logic         pu_q;
  logic         abort_q;
  logic         core_q;
  logic         async_q;
  logic         drv_lvl_q;

  logic         wr_acc;
  logic         wdt_ovf;
  logic         evt;
  logic         seq_end;
  wbrs_reg_t    wsel;

  assign wsel    = reg_sel(paddr);
  assign wr_acc  = psel & penable & pready_q & pwrite;
  assign wdt_ovf = (st_q == S_IDLE) & ~wdt_off_q & (div_q == 8'(WDT_PRESCALE - 1))
                 & (wdt_cnt_q == WDT_TOP);
  assign evt     = (st_q == S_IDLE) & (wdt_ovf | sw_req_q | ~filt_q);
  assign seq_end = (st_q == S_SEQ) & (cnt_q == SEQ_CYC - 11'h001);

  // Glitch filter: the pin level is passed on only once stable for FILT_CYC cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt_q <= 3'h0;
      filt_q     <= 1'b1;
    end else if (reset_in_pin == filt_q) begin
      filt_cnt_q <= 3'h0;
    end else if (filt_cnt_q == FILT_CYC - 3'h1) begin
      filt_cnt_q <= 3'h0;
      filt_q     <= reset_in_pin; // R23
    end else begin
      filt_cnt_q <= filt_cnt_q + 3'h1;
    end
  end

  // APB slave: one wait-free access phase, unmapped addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & (wsel == WBRS_R_NONE);
      if (psel && !penable) begin
        case (wsel)
          WBRS_R_SYSCFG: prdata_q <= 32'((32'(bidir_en_q) << BIT_BIDIR_EN)
                                        | (32'(pwd_cfg_q) << BIT_PWD_CFG));
          WBRS_R_WDTRLD: prdata_q <= {16'h0000, wdt_reload_q};
          WBRS_R_STATUS: prdata_q <= {20'h00000, flags_q, 1'b0, st_q, end_of_init_instr_done_q,
                                      reset_out_q, filt_q, wdt_off_q};
          WBRS_R_CFGLAT: prdata_q <= {16'h0000, cfg_lat_q};
          default:       prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration bits; the enable is cleared by every sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bidir_en_q   <= 1'b0;
      pwd_cfg_q    <= 1'b0;
      wdt_reload_q <= WDT_RELOAD_RST;
    end else if (evt) begin
      bidir_en_q <= 1'b0; // R16
    end else if (wr_acc && wsel == WBRS_R_SYSCFG) begin
      pwd_cfg_q <= pwdata[BIT_PWD_CFG];
      if (!end_of_init_instr_done_q) begin
        bidir_en_q <= pwdata[BIT_BIDIR_EN]; // R9 R10
      end
    end else if (wr_acc && wsel == WBRS_R_WDTRLD) begin
      wdt_reload_q <= pwdata[15:0];
    end
  end

  // Command strobes: software reset request and end of initialization.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req_q     <= 1'b0;
      end_of_init_instr_done_q <= 1'b0;
      reset_out_q  <= 1'b0;
    end else begin
      sw_req_q <= wr_acc & (wsel == WBRS_R_CMD) & pwdata[BIT_SW_RESET] & (st_q == S_IDLE);
      if (evt) begin
        end_of_init_instr_done_q <= 1'b0;
        reset_out_q  <= 1'b0; // R7
      end else if (wr_acc && wsel == WBRS_R_CMD && pwdata[BIT_END_INIT]
                   && st_q == S_IDLE) begin
        end_of_init_instr_done_q <= 1'b1;
        reset_out_q  <= 1'b1; // R8
      end
    end
  end

  // Watchdog: counts up on divided ticks, reloads on service, may be switched off
  // only while initialization is still open.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_q <= WDT_RELOAD_RST;
      wdt_off_q <= 1'b0;
      div_q     <= 8'h00;
    end else if (st_q != S_IDLE) begin
      wdt_cnt_q <= wdt_reload_q;
      wdt_off_q <= 1'b0;
      div_q     <= 8'h00;
    end else begin
      div_q <= (div_q == 8'(WDT_PRESCALE - 1)) ? 8'h00 : div_q + 8'h01;
      if (wr_acc && wsel == WBRS_R_CMD && pwdata[BIT_WDT_SERV]) begin
        wdt_cnt_q <= wdt_reload_q;
      end else if (!wdt_off_q && div_q == 8'(WDT_PRESCALE - 1)) begin
        wdt_cnt_q <= wdt_cnt_q + 16'h0001; // R1
      end
      if (wr_acc && wsel == WBRS_R_CMD && pwdata[BIT_WDT_OFF] && !end_of_init_instr_done_q) begin
        wdt_off_q <= 1'b1;
      end
    end
  end

  // Sequencer: source, phase counter, pull-down selection and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= S_IDLE;
      src_q    <= SRC_HW;
      cnt_q    <= 11'h000;
      bd_q     <= 1'b0;
      bd_sel_q <= 1'b0;
      flags_q  <= '0;
      abort_q  <= 1'b0;
    end else begin
      abort_q <= 1'b0;
      cnt_q   <= cnt_q + 11'h001;
      case (st_q)
        S_IDLE: begin
          cnt_q <= 11'h000;
          if (!filt_q && !powerdown_reset_pin) begin
            st_q    <= S_ASYNC; // R20
            bd_q    <= bidir_en_q;
            flags_q <= '{long_hw: 1'b1, short_hw: 1'b1, sw: 1'b1, wdt: 1'b0};
          end else if (!filt_q) begin
            st_q     <= S_START;
            src_q    <= SRC_HW;
            bd_q     <= bidir_en_q;
            bd_sel_q <= bidir_en_q;
            flags_q  <= '{long_hw: 1'b0, short_hw: 1'b1, sw: 1'b1, wdt: 1'b0};
          end else if (wdt_ovf || sw_req_q) begin
            st_q     <= (wdt_ovf && ext_bus.active) ? S_BUSW : S_START; // R2
            src_q    <= wdt_ovf ? SRC_WDT : SRC_SW;
            bd_q     <= bidir_en_q & powerdown_reset_pin; // R6 R14
            bd_sel_q <= bidir_en_q & powerdown_reset_pin;
            flags_q  <= '{long_hw: 1'b0, short_hw: 1'b0, sw: sw_req_q & ~wdt_ovf,
                          wdt: wdt_ovf};
          end
        end
        S_BUSW: begin
          cnt_q <= 11'h000;
          if (!ext_bus.active) begin
            st_q <= S_START; // R2
          end else if (ext_bus.uses_ready && ext_bus.waits_done && ext_bus.ready_n) begin
            abort_q <= 1'b1; // R3
            st_q    <= S_START;
          end
        end
        S_START: begin
          if (cnt_q == START_CYC - 11'h001) begin
            st_q  <= S_SEQ; // R22
            cnt_q <= 11'h000;
          end
        end
        S_SEQ: begin
          if (!powerdown_reset_pin && src_q != SRC_HW) begin
            bd_q <= 1'b0; // R15
          end
          if (src_q == SRC_HW && !filt_q && !powerdown_reset_pin) begin // R5
            st_q    <= S_ASYNC;
            flags_q <= '{long_hw: 1'b1, short_hw: 1'b1, sw: 1'b1, wdt: 1'b0};
          end else if (seq_end) begin
            st_q  <= S_POST; // R22
            bd_q  <= 1'b0; // R11
            cnt_q <= 11'h000;
          end
        end
        S_POST: begin
          if (cnt_q == SAMPLE_CYC - 11'h001) begin
            cnt_q <= 11'h000;
            if (src_q == SRC_HW) begin
              flags_q.long_hw <= ~filt_q; // R12 R21
              st_q            <= filt_q ? S_IDLE : S_EXT;
            end else if (bd_sel_q && !filt_q) begin
              st_q <= S_CHK; // R17
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        S_EXT: begin
          if (filt_q) begin
            st_q <= S_IDLE;
          end
        end
        S_CHK: begin
          if (filt_q) begin
            st_q <= S_IDLE; // R13
          end else if (cnt_q == SHORT_CYC - 11'h001) begin
            st_q     <= S_START; // R13 R17
            src_q    <= SRC_HW;
            cnt_q    <= 11'h000;
            bd_q     <= 1'b0;
            bd_sel_q <= 1'b0;
            flags_q  <= '{long_hw: 1'b0, short_hw: 1'b1, sw: 1'b1, wdt: 1'b0};
          end
        end
        S_ASYNC: begin
          cnt_q <= 11'h000;
          if (filt_q) begin
            st_q <= S_IDLE;
            bd_q <= 1'b0;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Configuration port capture at the end of the sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_lat_q <= 16'h0000;
    end else if (seq_end && src_q == SRC_HW) begin
      cfg_lat_q <= config_port;
    end else if (seq_end) begin
      cfg_lat_q[12:8] <= config_port[12:8] & CFG_HI_MASK_LO; // R4
      cfg_lat_q[7:2]  <= CFG_MID_ONES; // R4
    end
  end

  // Pin and core outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q    <= 1'b1;
      pd_q      <= 1'b0;
      pu_q      <= 1'b0;
      core_q    <= 1'b1;
      async_q   <= 1'b0;
      drv_lvl_q <= 1'b0;
    end else begin
      oe_n_q    <= ~(bd_q & (st_q == S_START || st_q == S_SEQ || st_q == S_ASYNC)); // R11
      pd_q      <= ~filt_q; // R19
      pu_q      <= pwd_cfg_q & (st_q == S_IDLE); // R18
      core_q    <= (st_q != S_IDLE);
      async_q   <= (st_q == S_ASYNC); // R20
      drv_lvl_q <= 1'b0;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign reset_in_out    = drv_lvl_q;
  assign reset_in_oe_n   = oe_n_q;
  assign reset_out_pin_n = reset_out_q;
  assign rpd_pulldown_en = pd_q;
  assign rpd_pullup_en   = pu_q;
  assign bus_abort       = abort_q;
  assign core_reset      = core_q;
  assign async_reset     = async_q;

  localparam int SEQ_LAST = int'(SEQ_CYC) - 1;
  localparam int SMP_LAST = int'(SAMPLE_CYC) - 1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_out_low;
    evt |=> !reset_out_q;
  endproperty
  a_out_low: assert property (p_out_low) else $error("reset out not low at event"); // R7

  property p_out_held;
    (st_q != S_IDLE) |-> !reset_out_q;
  endproperty
  a_out_held: assert property (p_out_held) else $error("reset out released early"); // R8

  property p_seq_len;
    (st_q == S_SEQ && cnt_q == 11'(SEQ_LAST) && src_q != SRC_HW) |=> st_q == S_POST;
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence length wrong"); // R22

  property p_pulldown;
    (st_q == S_SEQ && bd_q) |=> !oe_n_q;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down missing"); // R11

  property p_clear_en;
    evt |=> !bidir_en_q;
  endproperty
  a_clear_en: assert property (p_clear_en) else $error("enable not cleared"); // R16

  property p_late_set;
    (end_of_init_instr_done_q && !evt) |=> !$rose(bidir_en_q);
  endproperty
  a_late_set: assert property (p_late_set) else $error("enable set after init"); // R10

  property p_wdt_sync;
    (st_q == S_SEQ && src_q == SRC_WDT) |=> st_q != S_ASYNC;
  endproperty
  a_wdt_sync: assert property (p_wdt_sync) else $error("watchdog went async"); // R5

  property p_rpd_pd;
    !filt_q |=> pd_q;
  endproperty
  a_rpd_pd: assert property (p_rpd_pd) else $error("pull-down on power-down pin off"); // R19

  property p_release;
    (st_q == S_SEQ && src_q != SRC_HW && !powerdown_reset_pin && !seq_end) |-> ##2 oe_n_q;
  endproperty
  a_release: assert property (p_release) else $error("reset input not released"); // R15

  property p_sample;
    (st_q == S_POST && cnt_q == 11'(SMP_LAST) && src_q == SRC_HW && !filt_q)
      |=> flags_q.long_hw;
  endproperty
  a_sample: assert property (p_sample) else $error("long reset not flagged"); // R21

  c_wdt:   cover property (evt && wdt_ovf);
  c_abort: cover property (abort_q);
  c_chk:   cover property (st_q == S_CHK ##1 st_q == S_START);

endmodule

// ### verif/wbrs_partner.sv
/*
  Far-side model: the external reset circuitry on the reset input and
  power-down pins.
  Assumes the bench steers the external controls just after clock edges.
*/
`timescale 1ns/1ps
module wbrs_partner (
  // Device side of the reset input pin.
  input  wire logic reset_in_out,
  input  wire logic reset_in_oe_n,
  output logic      reset_in_pin,
  // External circuitry controls.
  input  wire logic ext_low_n,
  input  wire logic pd_level,
  output logic      powerdown_reset_pin
);
  // The reset input line is a wired AND of all drivers over a pull-up.
  assign reset_in_pin        = ext_low_n & (reset_in_oe_n | reset_in_out);
  assign powerdown_reset_pin = pd_level;
endmodule

// ### verif/wbrs_seq_test.sv
/*
  Self-checking bench of the reset sequencer.
  Assumes the APB slave answers without a fixed latency.
*/
`timescale 1ns/1ps
module wbrs_seq_test;
  import wbrs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, reset_in_pin, reset_in_out, reset_in_oe_n;
  logic        reset_out_pin_n, powerdown_reset_pin, rpd_pulldown_en, rpd_pullup_en;
  logic        bus_abort, core_reset, async_reset, hold = 0, pd_drop = 0;
  logic        ext_low_n = 1, pd_level = 1;
  wbrs_bus_t   ext_bus = '0;
  logic [15:0] config_port = 16'h0000;
  int          n_fail = 0, compares = 0, cyc = 0, seed = 26, hold_cnt = 0;
  int          n_core = 0, n_oe = 0, n_abort = 0, n_async = 0;

  always #50 pclk = ~pclk;

  wbrs_seq #(.WDT_PRESCALE(1)) u_wbrs_seq (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_in_pin(reset_in_pin), .reset_in_out(reset_in_out),
    .reset_in_oe_n(reset_in_oe_n), .reset_out_pin_n(reset_out_pin_n),
    .powerdown_reset_pin(powerdown_reset_pin), .rpd_pulldown_en(rpd_pulldown_en),
    .rpd_pullup_en(rpd_pullup_en), .ext_bus(ext_bus), .bus_abort(bus_abort),
    .config_port(config_port), .core_reset(core_reset), .async_reset(async_reset));

  wbrs_partner u_wbrs_partner (
    .reset_in_out(reset_in_out), .reset_in_oe_n(reset_in_oe_n),
    .reset_in_pin(reset_in_pin), .ext_low_n(ext_low_n), .pd_level(pd_level),
    .powerdown_reset_pin(powerdown_reset_pin));

  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_core(input logic want, input int lim);
    int n;
    n = 0;
    while (core_reset !== want && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(n < lim, 1, "reset sequence wait");
  endtask

  // Reset counters, launch a bidirectional software reset and check its outcome.
  task automatic run_sw(input logic [3:0] fl, input int cmin, cmax, omin, omax);
    config_port <= 16'($random(seed));
    apb(1'b1, ADDR_SYSCFG, 32'h28);
    apb(1'b0, ADDR_SYSCFG, 32'h0);
    chk(rd[5:3], 3'b101, "syscfg readback");
    n_core = 0;
    n_oe = 0;
    apb(1'b1, ADDR_CMD, 32'h4);
    wait_core(1'b1, 20);
    chk(reset_in_out, 1'b0, "pull-down drive level");
    wait_core(1'b0, 3000);
    chk(n_core >= cmin && n_core <= cmax, 1, "sequence length");
    chk(n_oe >= omin && n_oe <= omax, 1, "reset input pull-down time");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[11:8], fl, "source flags");
    check_latch(fl[2]);
    apb(1'b0, ADDR_SYSCFG, 32'h0);
    chk(rd[3], 1'b0, "bidir enable cleared");
  endtask

  // A hardware reset latches the whole port; software and watchdog only bits 12..8.
  task automatic check_latch(input logic hw);
    logic [15:0] want;
    apb(1'b0, ADDR_CFGLAT, 32'h0);
    want = hw ? (config_port & 16'h1FFC) : {3'b000, config_port[12:8], 8'hFC};
    chk(rd[15:0] & 16'h1FFC, want, "latched config");
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (core_reset === 1'b1) n_core++;
    if (reset_in_oe_n === 1'b0) n_oe++;
    if (bus_abort === 1'b1) n_abort++;
    if (async_reset === 1'b1) n_async++;
    if (hold && reset_in_oe_n === 1'b0) begin
      ext_low_n <= 1'b0;
    end else if (hold && ext_low_n === 1'b0) begin
      hold_cnt++;
      if (hold_cnt == 20) begin
        ext_low_n <= 1'b1;
        hold <= 1'b0;
      end
    end
    if (pd_drop && n_core == 100) pd_level <= 1'b0;
    if (pd_drop && n_core == 104) begin
      chk(reset_in_oe_n, 1'b1, "pull-down released on power-down low");
      pd_level <= 1'b1;
      pd_drop <= 1'b0;
    end
    if (cyc > 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(reset_out_pin_n, 1'b0, "reset output after reset");
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    run_sw(4'b0010, 1040, 1060, 1024, 1050);
    chk(rpd_pullup_en, 1'b1, "power-down pull-up");
    pd_level <= 1'b0;
    run_sw(4'b0010, 1040, 1060, 0, 0);
    pd_level <= 1'b1;
    pd_drop <= 1'b1;
    run_sw(4'b0010, 1040, 1060, 80, 110);
    hold <= 1'b1;
    hold_cnt = 0;
    run_sw(4'b0110, 2080, 2150, 1024, 1050);
    chk(reset_out_pin_n, 1'b0, "reset output held in init");
    apb(1'b1, ADDR_CMD, 32'h8);
    repeat (3) @(posedge pclk);
    chk(reset_out_pin_n, 1'b1, "reset output after end of init");
    apb(1'b1, ADDR_SYSCFG, 32'h8);
    apb(1'b0, ADDR_SYSCFG, 32'h0);
    chk(rd[3], 1'b0, "late bidir enable");
    for (int k = 0; k < 2; k++) begin
      ext_bus <= '{active: 1'b1, uses_ready: 1'b1, waits_done: 1'b1, ready_n: k == 0};
      pd_level <= (k == 0);
      config_port <= 16'($random(seed));
      n_abort = 0;
      n_async = 0;
      apb(1'b1, ADDR_WDTRLD, 32'hFF00 | (32'($random(seed)) & 32'h70));
      apb(1'b1, ADDR_CMD, 32'h1);
      wait_core(1'b1, 400);
      ext_bus <= '0;
      chk(reset_out_pin_n, 1'b0, "reset output at watchdog start");
      wait_core(1'b0, 3000);
      chk(n_abort, k == 0, "bus abort count");
      chk(n_async, 0, "watchdog stays synchronous");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[11:8], 4'b0001, "watchdog flags");
      check_latch(1'b0);
      ext_bus <= '0;
    end
    // Reset input held low past the sample point makes a long hardware reset.
    pd_level <= 1'b1;
    ext_low_n <= 1'b0;
    wait_core(1'b1, 20);
    repeat (1100) @(posedge pclk);
    chk(core_reset, 1'b1, "long reset extends");
    ext_low_n <= 1'b1;
    wait_core(1'b0, 20);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[11:8], 4'b1110, "long hardware flags");
    pd_level <= 1'b0;
    ext_low_n <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(async_reset, 1'b1, "asynchronous reset");
    chk(rpd_pulldown_en, 1'b1, "power-down pull-down");
    ext_low_n <= 1'b1;
    pd_level <= 1'b1;
    wait_core(1'b0, 3000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[11:8], 4'b1110, "asynchronous flags");
    give_verdict();
  end
endmodule
